// File: pkg/rtc_tick_map.vh
// Register map, field positions and timing constants of the tick timer.
`ifndef RTC_TICK_MAP_VH
`define RTC_TICK_MAP_VH

// Register indices; byte address is four times the index.
`define IDX_MATCH_LO   6'h0C
`define IDX_MATCH_HI   6'h0D
`define IDX_TICK_CTRL  6'h10
`define IDX_TICK_SYNC  6'h11
`define IDX_TICK_IEN   6'h12
`define IDX_TICK_FLAG  6'h13
`define IDX_TICK_DBG   6'h15
`define IDX_IRQ_STATUS 6'h18
`define IDX_IRQ_CLEAR  6'h19
`define IDX_IRQ_ENABLE 6'h1A

// Field positions.
`define CTRL_EN_BIT    0
`define CTRL_PER_HI    6
`define CTRL_PER_LO    3
`define CTRL_MASK      8'h79
`define DBG_RUN_BIT    0
`define IRQ_TICK_BIT   0
`define IRQ_MATCH_BIT  1

// Reset values and codes.
`define MATCH_RESET    8'h00
`define CTRL_RESET     8'h00
`define PER_OFF        4'h0
`define PER_RESERVED   4'hF
`define PRESCALE_ONE   15'h0001

// Number of slow clock edges a control write needs to take effect.
`define SYNC_EDGES     2'h2

// Bus responses.
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// File: rtl/rtc_tick_timer.v
// Compare value, periodic tick timer and AXI4-Lite register slave.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "rtc_tick_map.vh"

module rtc_tick_timer
(
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        rtc_clk,
  input  wire        debug_halted,
  input  wire [15:0] count_value,
  output reg         irq
);

  // Synchronizer state for the slow clock and debug halt pins, and edge detect state for the slow clock.
  reg        rtc_meta_q;
  reg        rtc_sync_q;
  reg        rtc_prev_q;
  reg        halt_meta_q;
  reg        halt_sync_q;
  // Bus side holding registers.
  reg        aw_hold_q;
  reg [7:0]  awaddr_q;
  reg        w_hold_q;
  reg [7:0]  wdata_q;
  reg        wstrb_q;
  // Software visible state.
  reg [7:0]  match_lo_q;
  reg [7:0]  match_hi_q;
  reg [7:0]  ctrl_shadow_q;
  reg [7:0]  ctrl_active_q;
  reg        sync_pending_q;
  reg [1:0]  sync_cnt_q;
  reg        run_while_halted_q;
  reg [1:0]  irq_en_q;
  reg [1:0]  irq_flag_q;
  // Timer state.
  reg [14:0] prescale_q;
  reg        equal_q;

  wire        rtc_edge;
  wire        halted;
  wire        tick_timer_enable;
  wire [3:0]  period_code;
  wire [14:0] period_mask;
  wire        tick_event;
  wire        match_event;
  wire        wr_fire;
  wire        wr_ok;
  wire [5:0]  wr_idx;
  wire        rd_fire;
  wire        rd_ok;
  wire [5:0]  rd_idx;

  reg  [1:0]  flag_clr;
  reg  [1:0]  flag_d;
  reg  [7:0]  rd_byte;
  reg         rd_hit;

  // Two flip-flops on each pin before any logic looks at it.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rtc_meta_q  <= 1'b0;
      rtc_sync_q  <= 1'b0;
      rtc_prev_q  <= 1'b0;
      halt_meta_q <= 1'b0;
      halt_sync_q <= 1'b0;
    end
    else
    begin
      rtc_meta_q  <= rtc_clk;
      rtc_sync_q  <= rtc_meta_q;
      rtc_prev_q  <= rtc_sync_q;
      halt_meta_q <= debug_halted;
      halt_sync_q <= halt_meta_q;
    end
  end

  // Rising edge of the slow clock, seen only on synchronized copies.
  assign rtc_edge = rtc_sync_q & ~rtc_prev_q;
  assign halted = halt_sync_q & ~run_while_halted_q;
  assign tick_timer_enable = ctrl_active_q[`CTRL_EN_BIT];
  assign period_code = ctrl_active_q[`CTRL_PER_HI:`CTRL_PER_LO];

  // interval mask select
  // Code n selects two to the power of n+1 slow cycles per interval.
  assign period_mask = ((`PRESCALE_ONE << period_code) << 1) - `PRESCALE_ONE;

  // tick on interval
  // The mask of all ones marks the last cycle of each interval.
  assign tick_event = rtc_edge & tick_timer_enable & ~halted &
                      (period_code != `PER_OFF) &
                      (period_code != `PER_RESERVED) &
                      ((prescale_q & period_mask) == period_mask);

  // free-running prescaler
  // Cleared while disabled so the first interval after enable is whole.
  always @(posedge aclk)
  begin
    if (!aresetn)
      prescale_q <= 15'h0000;
    else if (!tick_timer_enable)
      prescale_q <= 15'h0000;
    else if (rtc_edge && !halted)
      prescale_q <= prescale_q + `PRESCALE_ONE;
  end

  // match edge detect
  // Only the start of equality counts, so a held match sets once.
  always @(posedge aclk)
  begin
    if (!aresetn)
      equal_q <= 1'b0;
    else
      equal_q <= (count_value == {match_hi_q, match_lo_q});
  end
  assign match_event = (count_value == {match_hi_q, match_lo_q}) & ~equal_q;

  // Write channel: address and data taken independently, then one write.
  assign wr_fire = aw_hold_q & w_hold_q;
  assign wr_idx  = awaddr_q[7:2];
  assign wr_ok   = wr_fire & (awaddr_q[1:0] == 2'h0) & wstrb_q;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q     <= 1'b0;
      awaddr_q      <= 8'h00;
      w_hold_q      <= 1'b0;
      wdata_q       <= 8'h00;
      wstrb_q       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q     <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q     <= 1'b1;
        wdata_q      <= s_axi_wdata[7:0];
        wstrb_q      <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (rd_valid_idx(wr_idx) && awaddr_q[1:0] == 2'h0) ?
                        `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      else if (!s_axi_bvalid && !aw_hold_q && !w_hold_q &&
               !s_axi_awready && !s_axi_wready)
      begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Decodes which indices are mapped, for both the write and read side.
  function rd_valid_idx;
    input [5:0] idx;
    begin
      case (idx)
        `IDX_MATCH_LO, `IDX_MATCH_HI, `IDX_TICK_CTRL, `IDX_TICK_SYNC,
        `IDX_TICK_IEN, `IDX_TICK_FLAG, `IDX_TICK_DBG, `IDX_IRQ_STATUS,
        `IDX_IRQ_CLEAR, `IDX_IRQ_ENABLE:
          rd_valid_idx = 1'b1;
        default:
          rd_valid_idx = 1'b0;
      endcase
    end
  endfunction

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      match_lo_q <= `MATCH_RESET;
      match_hi_q <= `MATCH_RESET;
    end
    else if (wr_ok && wr_idx == `IDX_MATCH_LO)
      match_lo_q <= wdata_q;
    else if (wr_ok && wr_idx == `IDX_MATCH_HI)
      match_hi_q <= wdata_q;
  end

  // sync busy tracking
  // The written value reaches the timer after two slow clock edges.
  // A second write while busy restarts the wait and replaces the first.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_shadow_q  <= `CTRL_RESET;
      ctrl_active_q  <= `CTRL_RESET;
      sync_pending_q <= 1'b0;
      sync_cnt_q     <= 2'h0;
    end
    else if (wr_ok && wr_idx == `IDX_TICK_CTRL)
    begin
      ctrl_shadow_q  <= wdata_q & `CTRL_MASK;
      sync_pending_q <= 1'b1;
      sync_cnt_q     <= 2'h0;
    end
    else if (sync_pending_q && rtc_edge)
    begin
      if (sync_cnt_q + 2'h1 == `SYNC_EDGES)
      begin
        ctrl_active_q  <= ctrl_shadow_q;
        sync_pending_q <= 1'b0;
        sync_cnt_q     <= 2'h0;
      end
      else
        sync_cnt_q <= sync_cnt_q + 2'h1;
    end
  end

  // Debug run bit and interrupt enables.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      run_while_halted_q <= 1'b0;
      irq_en_q           <= 2'h0;
    end
    else if (wr_ok)
    begin
      if (wr_idx == `IDX_TICK_DBG)
        run_while_halted_q <= wdata_q[`DBG_RUN_BIT];
      if (wr_idx == `IDX_TICK_IEN)
        irq_en_q[`IRQ_TICK_BIT] <= wdata_q[`IRQ_TICK_BIT];
      if (wr_idx == `IDX_IRQ_ENABLE)
        irq_en_q <= wdata_q[1:0];
    end
  end

  // write one clears
  // Zero bits of the written byte leave the flags alone.
  always @*
  begin
    flag_clr = 2'h0;
    if (wr_ok && wr_idx == `IDX_TICK_FLAG)
      flag_clr[`IRQ_TICK_BIT] = wdata_q[`IRQ_TICK_BIT];
    if (wr_ok && wr_idx == `IDX_IRQ_CLEAR)
      flag_clr = wdata_q[1:0];
    // An event in the clearing cycle wins over the clear.
    flag_d = irq_flag_q & ~flag_clr;
    if (tick_event)
      flag_d[`IRQ_TICK_BIT] = 1'b1;
    if (match_event)
      flag_d[`IRQ_MATCH_BIT] = 1'b1;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_flag_q <= 2'h0;
      irq        <= 1'b0;
    end
    else
    begin
      irq_flag_q <= flag_d;
      irq        <= |(irq_flag_q & irq_en_q);
    end
  end

  // Read decode; write-only clear register reads as zero.
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign rd_idx  = s_axi_araddr[7:2];
  assign rd_ok   = (s_axi_araddr[1:0] == 2'h0) & rd_valid_idx(rd_idx);

  always @*
  begin
    rd_byte = 8'h00;
    rd_hit  = rd_ok;
    case (rd_idx)
      `IDX_MATCH_LO:   rd_byte = match_lo_q;
      `IDX_MATCH_HI:   rd_byte = match_hi_q;
      `IDX_TICK_CTRL:  rd_byte = ctrl_shadow_q;
      `IDX_TICK_SYNC:  rd_byte = {7'h00, sync_pending_q};
      `IDX_TICK_IEN:   rd_byte = {7'h00, irq_en_q[`IRQ_TICK_BIT]};
      `IDX_TICK_FLAG:  rd_byte = {7'h00, irq_flag_q[`IRQ_TICK_BIT]};
      `IDX_TICK_DBG:   rd_byte = {7'h00, run_while_halted_q};
      `IDX_IRQ_STATUS: rd_byte = {6'h00, irq_flag_q};
      `IDX_IRQ_ENABLE: rd_byte = {6'h00, irq_en_q};
      default:         rd_byte = 8'h00;
    endcase
    if (!rd_hit)
      rd_byte = 8'h00;
  end

  // Read channel: one read at a time, answered the cycle after address.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, rd_byte};
      s_axi_rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

endmodule
`default_nettype wire

// File: bench/rtc_tick_timer_chk.sv
// Port-level assertions for the tick timer register slave.
`timescale 1ns/1ns
`default_nettype none
module rtc_tick_timer_chk
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Every register is one byte, so the upper read bits must be zero.
  AST_RD_UPPER:
  assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("Read data carries bits above the byte.");
  AST_R_HOLD:
  assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read answer dropped before it was taken.");
  AST_R_AFTER:
  assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read answer late.");
  AST_UNMAPPED:
  assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == 8'h38 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 0)
    else $error("Unmapped read not refused.");
  AST_B_HOLD:
  assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write answer dropped before it was taken.");
  // Both halves are held one cycle, so the answer shows two edges later.
  AST_B_AFTER:
  assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("Write answer late.");
  AST_NO_AW_BUSY:
  assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("Write taken while one is pending.");
  // The interrupt may only fall as the result of a register write.
  AST_IRQ_FALL:
  assert property ($fell(irq) |-> $past(s_axi_bvalid) ||
    $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3))
    else $error("Interrupt fell without a write.");
  COV_IRQ: cover property ($rose(irq));
  COV_SLVERR: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind rtc_tick_timer rtc_tick_timer_chk rtc_tick_timer_chk_i
(
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_araddr(s_axi_araddr),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rresp(s_axi_rresp), .s_axi_rdata(s_axi_rdata),
  .irq(irq)
);
`default_nettype wire

// File: bench/rtc_tick_timer_bench.sv
// Register-level testbench for the tick timer block.
`timescale 1ns/1ns
`default_nettype none
module rtc_tick_timer_bench;
  logic        aclk, aresetn, awv, wv, arv, bq, rq, rtc_clk, dbg;
  logic [7:0]  awa, ara;
  logic [31:0] wd, q;
  logic [3:0]  ws;
  logic [15:0] cv;
  logic [1:0]  rsp;
  wire         awr, wr, bv, arr, rv, irq;
  wire [1:0]   br, rr;
  wire [31:0]  rdat;
  integer      n_mismatch, tests_run, cyc, t0, i, k;
  logic [7:0]  ad [9] = '{8'h30, 8'h34, 8'h40, 8'h44, 8'h48, 8'h4C, 8'h54,
                          8'h60, 8'h68};
  rtc_tick_timer rtc_tick_timer_i
  (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bq),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rq), .rtc_clk(rtc_clk), .debug_halted(dbg),
    .count_value(cv), .irq(irq)
  );
  initial
  begin
    aclk = 0;
    forever #20 aclk = ~aclk;
  end
  // Slow clock of eight system cycles, well inside the sync limit.
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3) rtc_clk <= ~rtc_clk;
  end
  task end_sim;
    begin
      $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run++;
      if (got !== exp)
      begin
        n_mismatch++;
        $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  // Each channel is released at the rising edge at which its ready is seen.
  task xfer(input bit w, input [7:0] a, input [31:0] d);
    bit done;
    begin
      @(posedge aclk);
      if (w) {awa, wd, awv, wv, bq} <= {a, d, 3'b111};
      else {ara, arv, rq} <= {a, 2'b11};
      done = 0;
      while (!done)
      begin
        @(posedge aclk);
        if (awv && awr) awv <= 0;
        if (wv && wr) wv <= 0;
        if (arv && arr) arv <= 0;
        if (w ? (bq && bv) : (rq && rv))
        begin
          rsp = w ? br : rr;
          if (!w) q = rdat;
          {bq, rq} <= 2'b00;
          done = 1;
        end
      end
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      xfer(0, a, 0);
      chk(q, e);
    end
  endtask
  task sync_wait;
    begin
      for (i = 0; i < 40 && (i == 0 || q[0]); i++) xfer(0, 8'h44, 0);
      if (q[0] !== 1'b0)
      begin
        n_mismatch++;
        $display("CHECK FAILED %0t control sync never finished", $time);
      end
    end
  endtask
  // The first wait lets a clear issued at this edge settle first.
  task wirq;
    begin
      @(negedge aclk);
      for (t0 = 0; t0 < 3000 && irq !== 1'b1; t0++) @(negedge aclk);
      if (irq !== 1'b1)
      begin
        n_mismatch++;
        $display("CHECK FAILED %0t no tick interrupt", $time);
      end
    end
  endtask
  initial
  begin
    {awa, ara, wd, awv, wv, arv, bq, rq, rtc_clk, dbg} = 0;
    {n_mismatch, tests_run, cyc} = 0;
    ws = 4'hF;
    cv = 16'hFFFF;
    aresetn = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    for (int j = 0; j < 9; j++) rd(ad[j], 0);
    xfer(1, 8'h30, 32'hFFFFFFA5);
    xfer(1, 8'h34, 32'h5A);
    chk(rsp, 0);
    rd(8'h30, 32'hA5);
    rd(8'h34, 32'h5A);
    xfer(0, 8'h38, 0);
    chk(rsp, 2);
    xfer(1, 8'h38, 1);
    chk(rsp, 2);
    // A write with its low strobe off or a misaligned address has no effect.
    ws <= 4'h0;
    xfer(1, 8'h30, 32'h11);
    ws <= 4'hF;
    chk(rsp, 0);
    xfer(1, 8'h31, 32'h11);
    chk(rsp, 2);
    rd(8'h30, 32'hA5);
    xfer(1, 8'h48, 1);
    // Reserved code, then code zero, then disabled: all stay silent.
    xfer(1, 8'h40, 32'hFF);
    rd(8'h44, 1);
    rd(8'h40, 32'h79);
    sync_wait;
    chk(q[0], 0);
    repeat (300) @(posedge aclk);
    chk(irq, 0);
    xfer(1, 8'h40, 1);
    sync_wait;
    repeat (100) @(posedge aclk);
    chk(irq, 0);
    xfer(1, 8'h40, 8);
    sync_wait;
    repeat (100) @(posedge aclk);
    chk(irq, 0);
    // Time between two ticks is the selected count of slow cycles.
    for (int c = 1; c < 5; c++)
    begin
      xfer(1, 8'h40, c * 8 + 1);
      sync_wait;
      xfer(1, 8'h4C, 1);
      wirq;
      k = cyc;
      xfer(1, 8'h4C, 1);
      wirq;
      chk(cyc - k, 8 << (c + 1));
    end
    xfer(1, 8'h4C, 0);
    rd(8'h4C, 1);
    xfer(1, 8'h4C, 1);
    rd(8'h4C, 0);
    xfer(1, 8'h48, 0);
    repeat (600) @(posedge aclk);
    chk(irq, 0);
    rd(8'h4C, 1);
    xfer(1, 8'h48, 1);
    repeat (3) @(posedge aclk);
    chk(irq, 1);
    xfer(1, 8'h40, 9);
    sync_wait;
    dbg <= 1;
    xfer(1, 8'h4C, 1);
    repeat (200) @(posedge aclk);
    rd(8'h4C, 0);
    xfer(1, 8'h54, 1);
    rd(8'h54, 1);
    repeat (100) @(posedge aclk);
    rd(8'h4C, 1);
    dbg <= 0;
    xfer(1, 8'h40, 0);
    sync_wait;
    xfer(1, 8'h64, 3);
    xfer(1, 8'h30, 32'h34);
    xfer(1, 8'h34, 32'h12);
    cv <= 16'h1234;
    repeat (4) @(posedge aclk);
    cv <= 16'h0000;
    rd(8'h60, 2);
    chk(irq, 0);
    xfer(1, 8'h68, 3);
    repeat (3) @(posedge aclk);
    chk(irq, 1);
    rd(8'h68, 3);
    xfer(1, 8'h64, 2);
    rd(8'h60, 0);
    rd(8'h64, 0);
    end_sim;
  end
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    end_sim;
  end
endmodule
`default_nettype wire
